// ---- core/tape_pkg.sv ----
package tape_pkg;
  // Register byte offsets, decoded on the low address nibble.
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] DATA_OFS   = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;
  localparam logic [3:0] SELECT_OFS = 4'hC;
  // Control register fields and reset value.
  localparam int         MODE_LSB   = 0;
  localparam int         REV_BIT    = 2;
  localparam int         GO_BIT     = 3;
  localparam logic [3:0] CTRL_RST   = 4'h0;
  localparam logic [1:0] MODE_READ  = 2'h2;
  localparam logic [1:0] MODE_WRITE = 2'h3;
  // Status word bit positions.
  localparam int ST_DATA  = 0;
  localparam int ST_BLOCK = 1;
  localparam int ST_ERROR = 2;
  localparam int ST_END   = 3;
  localparam int ST_LATE  = 4;
  localparam int ST_REV   = 5;
  localparam int ST_GO    = 6;
  localparam int ST_MARK  = 7;
  localparam int ST_UNABL = 8;
  // Tape word width and the minus-zero checksum seed.
  localparam int          WORD_W     = 18;
  localparam logic [17:0] MINUS_ZERO = 18'h3FFFF;
  // Block gap timing, nominal for forward motion.
  localparam int CLK_NS        = 20;
  localparam int READ_GAP_US   = 1400;
  localparam int WRITE_GAP_US  = 1600;
  localparam int READ_GAP_CYC  = READ_GAP_US * 1000 / CLK_NS;
  localparam int WRITE_GAP_CYC = WRITE_GAP_US * 1000 / CLK_NS;
  // Wishbone request from the master.
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wbReq_t;
  // Events and data from the transport heads and tracks.
  typedef struct packed {
    logic        wordSlot;
    logic        sumSlot;
    logic        lastBlockWord;
    logic        farEnd;
    logic        markTrackFault;
    logic        unable;
    logic [17:0] word;
  } tapeIn_t;
  // Commands and data toward the transport.
  typedef struct packed {
    logic        go;
    logic        reverse;
    logic        writeStrobe;
    logic        sumAtForward;
    logic [17:0] word;
  } tapeOut_t;
  typedef enum {SQ_WORDS, SQ_GAP} seq_t;
endpackage

// ---- core/tape_word_transfer_flags.sv ----
// Operation
// - Read data flag; host takes word quickly
// - First read flag carries reverse checksum
// - Read to write skips one word
// - Write data flag; host supplies word
// - Entering write writes minus-zero checksum first
// - First write flag requests first word
// - Read block flag, data flag after gap
// - Write block flag requests checksum; gap
// - Mode change at last word deferred
// - Error only from end, late, mark
// - Far end: end bit, error, stop
// - Uncleared flag overrun sets late bit
// - Track faults set mark fault bit
// - Status read returns bits zero to eight
// - Reverse timing within twenty percent
// - Late bit means slow host service
// - Select, load clear; commands clear flags
// - Status word bit layout fixed
//
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
module tape_word_transfer_flags #(
  parameter int readGapCycles  = tape_pkg::READ_GAP_CYC,
  parameter int writeGapCycles = tape_pkg::WRITE_GAP_CYC
) (
  // Clock and reset.
  input  wire logic               mclk,
  input  wire logic               srst,
  // Wishbone slave.
  input  wire tape_pkg::wbReq_t   wbReq,
  output logic                    wbAck,
  output logic [31:0]             wbDatOut,
  // Transport side.
  input  wire tape_pkg::tapeIn_t  tapeIn,
  output tape_pkg::tapeOut_t      tapeOut,
  // Flags toward the host.
  output logic                    dataFlag,
  output logic                    blockFlag,
  output logic                    errorFlag
);
  import tape_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Bus decode.
  logic        next_wbAck;     // Ack one cycle after the strobe.
  logic [31:0] next_wbDatOut;  // Read data captured with the ack.
  logic        hit;            // The edge at which the access completes.
  logic        wrCtrl;         // Load-control command.
  logic        wrData;         // Write-word command.
  logic        rdData;         // Read-word command.
  logic        wrSel;          // Unit-select command.
  logic [8:0]  status;         // Assembled status word.

  //////////////////////////////////////////////////////////////////////////
  // Core state.
  logic [3:0]        ctrl, next_ctrl;         // Mode, reverse, go.
  logic [3:0]        pendCtrl, next_pendCtrl; // Deferred control word.
  logic              pendValid, next_pendValid;
  logic              sumPending, next_sumPending;
  logic              skipOne, next_skipOne;
  logic [WORD_W-1:0] wordBuffer, next_wordBuffer;
  logic              endBit, next_endBit;
  logic              lateBit, next_lateBit;
  logic              markBit, next_markBit;
  logic              unableBit, next_unableBit;
  logic [16:0]       gapCnt, next_gapCnt;
  seq_t              seq, next_seq;
  logic              next_dataFlag, next_blockFlag, next_errorFlag;
  tapeOut_t          next_tapeOut;
  logic              clearAll;   // Clears error, bits and flags.
  logic              clearDb;    // Clears data and block flags.
  logic              setData;    // Hardware raises the data flag.
  logic              setBlock;   // Hardware raises the block flag.
  logic              lateEv;     // A flag arrived on top of its twin.
  logic              errSet;     // Any error cause this cycle.
  logic              inRead, inWrite, gapDone;
  logic [16:0]       gapLimit;

  // The completing edge is the one that sees ack high, so command
  // side effects happen once per access, never on the request edge.
  always_comb begin
    hit    = wbReq.cyc && wbReq.stb && wbAck;
    wrCtrl = hit && wbReq.we && wbReq.sel[0] && wbReq.adr == CTRL_OFS;
    wrData = hit && wbReq.we && wbReq.sel[0] && wbReq.adr == DATA_OFS;
    wrSel  = hit && wbReq.we && wbReq.sel[0] && wbReq.adr == SELECT_OFS;
    rdData = hit && !wbReq.we && wbReq.adr == DATA_OFS;
    // Fixed bit layout of the status word.
    status = {unableBit, markBit, ctrl[GO_BIT], ctrl[REV_BIT], lateBit,
              endBit, errorFlag, blockFlag, dataFlag};
    next_wbAck    = wbReq.cyc && wbReq.stb && !wbAck;
    next_wbDatOut = 32'h0;
    // Unmapped offsets read as zero and still answer.
    if (wbReq.adr == CTRL_OFS) begin
      next_wbDatOut = {28'h0, ctrl};
    end else if (wbReq.adr == DATA_OFS) begin
      next_wbDatOut = {14'h0, wordBuffer};
    end else if (wbReq.adr == STATUS_OFS) begin
      next_wbDatOut = {23'h0, status};
    end
  end

  // Bus registers.
  always_ff @(posedge mclk) begin
    if (srst) begin
      wbAck    <= 1'b0;
      wbDatOut <= 32'h0;
    end else begin
      wbAck    <= next_wbAck;
      wbDatOut <= next_wbDatOut;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Flag, timing and transfer logic.
  always_comb begin
    next_ctrl       = ctrl;
    next_pendCtrl   = pendCtrl;
    next_pendValid  = pendValid;
    next_sumPending = sumPending;
    next_skipOne    = skipOne;
    next_wordBuffer = wordBuffer;
    next_gapCnt     = gapCnt;
    next_seq        = seq;
    next_unableBit  = tapeIn.unable;
    next_tapeOut    = tapeOut;
    next_tapeOut.writeStrobe = 1'b0;
    setData  = 1'b0;
    setBlock = 1'b0;
    clearAll = wrCtrl || wrSel;
    clearDb  = clearAll || rdData || wrData;
    inRead   = ctrl[GO_BIT] && ctrl[1:0] == MODE_READ;
    inWrite  = ctrl[GO_BIT] && ctrl[1:0] == MODE_WRITE;
    // Reverse motion uses the nominal counts; the transport's own
    // spread stays inside the tolerance the host must allow for.
    gapLimit = inRead ? 17'(readGapCycles) : 17'(writeGapCycles);
    gapDone  = seq == SQ_GAP && gapCnt >= gapLimit - 17'h1;
    // Read mode: buffer the head word and raise the flags.
    if (inRead && seq == SQ_WORDS && tapeIn.wordSlot) begin
      next_wordBuffer = tapeIn.word;
      setData         = 1'b1;
    end else if (inRead && seq == SQ_WORDS && tapeIn.sumSlot) begin
      next_wordBuffer = tapeIn.word;
      setBlock        = 1'b1;
      next_seq        = SQ_GAP;
      next_gapCnt     = 17'h0;
    end else if (inRead && gapDone) begin
      // The first word of the block is the reverse checksum.
      next_wordBuffer = tapeIn.word;
      setData         = 1'b1;
      next_seq        = SQ_WORDS;
    end else if (inWrite && seq == SQ_WORDS && tapeIn.wordSlot) begin
      // A word slot both writes the last supplied word and asks for
      // the next one; the slot after a read-to-write switch is idle.
      if (skipOne) begin
        next_skipOne = 1'b0;
      end else begin
        next_tapeOut.writeStrobe = 1'b1;
        next_tapeOut.word        = wordBuffer;
      end
      if (tapeIn.lastBlockWord) begin
        next_sumPending = 1'b1;
      end
      setData = 1'b1;
    end else if (inWrite && seq == SQ_WORDS && tapeIn.sumSlot) begin
      setBlock    = 1'b1;
      next_seq    = SQ_GAP;
      next_gapCnt = 17'h0;
    end else if (inWrite && gapDone) begin
      // Checksum goes out and the deferred mode change applies in the same cycle.
      next_tapeOut.writeStrobe  = 1'b1;
      next_tapeOut.word         = wordBuffer;
      next_tapeOut.sumAtForward = !ctrl[REV_BIT];
      next_sumPending           = 1'b0;
      next_seq                  = SQ_WORDS;
      setData                   = 1'b1;
      if (pendValid) begin
        next_ctrl      = pendCtrl;
        next_pendValid = 1'b0;
      end
    end else if (seq == SQ_GAP && (inRead || inWrite)) begin
      // The gap runs only while the tape moves in a transfer mode, so a
      // stop inside a gap cannot drive the counter past its limit.
      next_gapCnt = gapCnt + 17'h1;
    end
    // Host loads the buffer with the word or the checksum.
    if (wrData) begin
      next_wordBuffer = wbReq.dat[WORD_W-1:0];
    end
    // Load control: defer while a written block still owes its sum.
    if (wrCtrl && inWrite && sumPending) begin
      next_pendCtrl  = wbReq.dat[3:0];
      next_pendValid = 1'b1;
    end else if (wrCtrl) begin
      next_ctrl = wbReq.dat[3:0];
      next_seq  = SQ_WORDS;
      // Leaving write mode drops any owed checksum, so a later entry
      // into write mode does not defer its commands for no reason.
      if (wbReq.dat[1:0] != MODE_WRITE) begin
        next_sumPending = 1'b0;
      end
      if (wbReq.dat[1:0] == MODE_WRITE && ctrl[1:0] != MODE_WRITE) begin
        // Seed the checksum slot chosen by the commanded direction.
        next_tapeOut.writeStrobe  = 1'b1;
        next_tapeOut.word         = MINUS_ZERO;
        next_tapeOut.sumAtForward = !wbReq.dat[REV_BIT];
        next_skipOne              = ctrl[1:0] == MODE_READ;
      end
    end
    // Far end of tape stops motion regardless of the command.
    if (tapeIn.farEnd) begin
      next_ctrl[GO_BIT] = 1'b0;
      next_pendValid    = 1'b0;
      next_sumPending   = 1'b0;
    end
    // Overrun: a new flag while the previous is still standing, and
    // not being cleared now, means the host serviced too slowly.
    lateEv = (setData && dataFlag && !clearDb) ||
             (setBlock && blockFlag && !clearDb);
    errSet = lateEv || tapeIn.farEnd || tapeIn.markTrackFault;
    // Set wins over clear for every sticky flag and bit.
    next_dataFlag  = (dataFlag && !clearDb) || setData;
    next_blockFlag = (blockFlag && !clearDb) || setBlock;
    next_errorFlag = (errorFlag && !clearAll) || errSet;
    next_endBit    = (endBit && !clearAll) || tapeIn.farEnd;
    next_lateBit   = (lateBit && !clearAll) || lateEv;
    next_markBit   = (markBit && !clearAll) ||
                     tapeIn.markTrackFault;
    next_tapeOut.go      = next_ctrl[GO_BIT];
    next_tapeOut.reverse = next_ctrl[REV_BIT];
  end

  // Core registers.
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl       <= CTRL_RST;
      pendCtrl   <= CTRL_RST;
      pendValid  <= 1'b0;
      sumPending <= 1'b0;
      skipOne    <= 1'b0;
      wordBuffer <= '0;
      endBit     <= 1'b0;
      lateBit    <= 1'b0;
      markBit    <= 1'b0;
      unableBit  <= 1'b0;
      gapCnt     <= 17'h0;
      seq        <= SQ_WORDS;
      dataFlag   <= 1'b0;
      blockFlag  <= 1'b0;
      errorFlag  <= 1'b0;
      tapeOut    <= '0;
    end else begin
      ctrl       <= next_ctrl;
      pendCtrl   <= next_pendCtrl;
      pendValid  <= next_pendValid;
      sumPending <= next_sumPending;
      skipOne    <= next_skipOne;
      wordBuffer <= next_wordBuffer;
      endBit     <= next_endBit;
      lateBit    <= next_lateBit;
      markBit    <= next_markBit;
      unableBit  <= next_unableBit;
      gapCnt     <= next_gapCnt;
      seq        <= next_seq;
      dataFlag   <= next_dataFlag;
      blockFlag  <= next_blockFlag;
      errorFlag  <= next_errorFlag;
      tapeOut    <= next_tapeOut;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_read_word_flag: assert property (inRead && seq == SQ_WORDS &&
    tapeIn.wordSlot && !wrData |=> dataFlag &&
    wordBuffer == $past(tapeIn.word))
    else $error("read word not flagged");
  a_gap_bound: assert property (seq == SQ_GAP |->
    gapCnt < gapLimit)
    else $error("gap counter overran");
  a_gap_flag: assert property (inRead && gapDone && !clearDb
    |=> dataFlag && seq == SQ_WORDS)
    else $error("no flag after read gap");
  a_seed_zero: assert property (wrCtrl && !(inWrite && sumPending) &&
    wbReq.dat[1:0] == MODE_WRITE && ctrl[1:0] != MODE_WRITE
    |=> tapeOut.writeStrobe && tapeOut.word == MINUS_ZERO)
    else $error("minus zero seed missing");
  a_defer_mode: assert property (pendValid |-> sumPending ||
    tapeIn.farEnd)
    else $error("deferred mode without pending sum");
  a_far_end: assert property (tapeIn.farEnd |=>
    !tapeOut.go && errorFlag && endBit)
    else $error("far end did not stop tape");
  a_late_bit: assert property (lateEv |=> lateBit && errorFlag)
    else $error("overrun not reported");
  a_mark_bit: assert property (tapeIn.markTrackFault |=>
    markBit && errorFlag)
    else $error("mark fault not reported");
  a_error_cause: assert property ($rose(errorFlag) |->
    $past(errSet))
    else $error("error flag without cause");
  a_clear_all: assert property (wrSel && !errSet |=>
    !errorFlag && !lateBit && !endBit && !markBit)
    else $error("select did not clear errors");
  a_flag_sticky: assert property (dataFlag && !clearDb |=>
    dataFlag)
    else $error("data flag dropped uncleared");
  a_status_read: assert property (next_wbAck && !wbReq.we &&
    wbReq.adr == STATUS_OFS |=> wbDatOut[8:0] == $past(status) &&
    wbDatOut[31:9] == 23'h0)
    else $error("status read wrong");

  c_read_block: cover property (inRead && setBlock);
  c_write_sum: cover property (inWrite && gapDone);
  c_late: cover property (lateEv);
endmodule // tape_word_transfer_flags

// ---- verification/tape_transport_model.sv ----
`timescale 1ns/10ps
module tape_transport_model #(
  parameter int period     = 40,
  parameter int blockWords = 3
) (
  // Clock and reset.
  input  wire logic               mclk,
  input  wire logic               srst,
  // Motion command and injected faults.
  input  wire logic               go,
  input  wire logic               farEnd,
  input  wire logic               markFault,
  input  wire logic               unable,
  // Toward the block.
  output tape_pkg::tapeIn_t       tapeIn
);
  import tape_pkg::*;
  logic [7:0]  tick;    // Cycles since the last slot.
  logic [2:0]  slot;    // Word slots passed in this block.
  logic [17:0] serial;  // Next word to present.
  ////////////////////////////////////////////////////////////////////////
  // Slots pass only while the tape moves, like a real transport.
  // Outside a slot the read line toggles, so stale data never looks valid.
  always_ff @(posedge mclk) begin
    tapeIn.wordSlot       <= 1'b0;
    tapeIn.sumSlot        <= 1'b0;
    tapeIn.lastBlockWord  <= 1'b0;
    tapeIn.word           <= ~tapeIn.word;
    tapeIn.farEnd         <= farEnd;
    tapeIn.markTrackFault <= markFault;
    tapeIn.unable         <= unable;
    if (srst || !go) begin
      tick   <= 8'h00;
      slot   <= 3'h0;
      serial <= 18'h00101;
    end else if (tick == 8'(period - 1)) begin
      tick        <= 8'h00;
      tapeIn.word <= serial;
      serial      <= serial + 18'h00111;
      if (slot == 3'(blockWords)) begin
        tapeIn.sumSlot <= 1'b1;  // Block end carries the forward sum.
        slot           <= 3'h0;
      end else begin
        tapeIn.wordSlot      <= 1'b1;
        tapeIn.lastBlockWord <= (slot == 3'(blockWords - 1));
        slot                 <= slot + 3'h1;
      end
    end else begin
      tick <= tick + 8'h01;
    end
  end
endmodule // tape_transport_model

// ---- verification/test_tape_word_transfer_flags.sv ----
`timescale 1ns/10ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin errTotal++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
module test_tape_word_transfer_flags;
  import tape_pkg::*;
  typedef struct packed {
    logic        we;
    logic [3:0]  adr;
    logic [31:0] dat;
    logic [31:0] exp;
  } row_t;
  logic        mclk, srst, farEnd, markFault, unable;
  wbReq_t      wbReq;
  logic        wbAck, dataFlag, blockFlag, errorFlag;
  logic [31:0] wbDatOut, rd;
  tapeIn_t     tapeIn;
  tapeOut_t    tapeOut;
  logic [17:0] expWord, lastStrobe;
  int          errTotal, comparisons, i, n;
  // Plain register traffic while the tape stands still.
  row_t rows [7] = '{'{1'b1, CTRL_OFS, 32'h6, 32'h0},
    '{1'b0, CTRL_OFS, 32'h0, 32'h6}, '{1'b0, STATUS_OFS, 32'h0, 32'h20},
    '{1'b0, 4'h2, 32'h0, 32'h0}, '{1'b1, SELECT_OFS, 32'h0, 32'h0},
    '{1'b0, CTRL_OFS, 32'h0, 32'h6}, '{1'b1, CTRL_OFS, 32'h0, 32'h0}};
  tape_word_transfer_flags #(.readGapCycles(20), .writeGapCycles(24)) uut (
    .mclk(mclk), .srst(srst), .wbReq(wbReq), .wbAck(wbAck),
    .wbDatOut(wbDatOut), .tapeIn(tapeIn), .tapeOut(tapeOut),
    .dataFlag(dataFlag), .blockFlag(blockFlag), .errorFlag(errorFlag));
  tape_transport_model far (.mclk(mclk), .srst(srst), .go(tapeOut.go),
    .farEnd(farEnd), .markFault(markFault), .unable(unable),
    .tapeIn(tapeIn));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Track what the heads saw and what the block wrote.
  always @(posedge mclk) begin
    if (tapeIn.wordSlot | tapeIn.sumSlot) expWord <= tapeIn.word;
    if (tapeOut.writeStrobe) lastStrobe <= tapeOut.word;
  end
  ////////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("Compares %0d mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Classic cycle: hold until ack is sampled, then release for a cycle.
  task automatic wb(input logic we, input logic [3:0] adr,
                    input logic [31:0] dat, output logic [31:0] q);
    int k;
    wbReq <= '{1'b1, 1'b1, we, adr, 4'hF, dat};
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (wbAck === 1'b1) break;
    end
    if (k == 50) begin
      $display("wrong value ack exp 1 got 0");
      errTotal++;
      finish_test();
    end
    q = wbDatOut;
    wbReq <= '0;
    @(posedge mclk);
  endtask
  // Bounded wait for the data flag (0) or the block flag (1).
  task automatic waitSig(input int k);
    int c;
    for (c = 0; c < 500; c++) begin
      @(posedge mclk);
      if ((k == 0 ? dataFlag : blockFlag) === 1'b1) return;
    end
    $display("wrong value flag wait exp 1 got 0");
    errTotal++;
    finish_test();
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    wbReq = '0;
    farEnd = 1'b0;
    markFault = 1'b0;
    unable = 1'b0;
    errTotal = 0;
    comparisons = 0;
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    wb(1'b0, STATUS_OFS, 32'h0, rd);
    `CHK("status", 32'h0, rd)
    for (i = 0; i < 7; i++) begin
      wb(rows[i].we, rows[i].adr, rows[i].dat, rd);
      if (!rows[i].we) `CHK("row", rows[i].exp, rd)
    end
    // Read a word, then take the block end and time the gap.
    wb(1'b1, CTRL_OFS, 32'hA, rd);
    waitSig(0);
    wb(1'b0, DATA_OFS, 32'h0, rd);
    `CHK("word", expWord, rd[17:0])
    `CHK("clear", 1'b0, dataFlag)
    waitSig(1);
    wb(1'b0, DATA_OFS, 32'h0, rd);
    `CHK("fsum", expWord, rd[17:0])
    for (n = 0; n < 100 && dataFlag !== 1'b1; n++) @(posedge mclk);
    `CHK("gap", 1'b1, n >= 14 && n <= 20)
    // Leave the checksum flag standing so the next slot overruns it.
    repeat (60) @(posedge mclk);
    `CHK("sticky", 1'b1, dataFlag)
    wb(1'b0, STATUS_OFS, 32'h0, rd);
    `CHK("late", 3'h5, {rd[4], rd[3], rd[2]})
    // Search with the tape moving: no transfer flag can interfere now.
    wb(1'b1, CTRL_OFS, 32'h9, rd);
    `CHK("lcclr", 3'h0, {dataFlag, blockFlag, errorFlag})
    unable <= 1'b1;
    markFault <= 1'b1;
    @(posedge mclk);
    markFault <= 1'b0;
    repeat (4) @(posedge mclk);
    wb(1'b0, STATUS_OFS, 32'h0, rd);
    // Tape unable shows in status but raises no error of its own.
    `CHK("mark", 4'hD, {rd[8], rd[7], rd[4], rd[2]})
    unable <= 1'b0;
    farEnd <= 1'b1;
    @(posedge mclk);
    farEnd <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK("stop", 1'b0, tapeOut.go)
    wb(1'b0, STATUS_OFS, 32'h0, rd);
    `CHK("end", 2'h3, {rd[3], rd[2]})
    wb(1'b1, SELECT_OFS, 32'h0, rd);
    `CHK("selclr", 1'b0, errorFlag)
    // Entering write seeds minus zero in the slot of the direction; the
    // strobe stands for one cycle, which is the cycle looked at here.
    // The second entry comes from read mode and so idles one slot.
    for (i = 0; i < 2; i++) begin
      wb(1'b1, CTRL_OFS, i ? 32'h2 : 32'h0, rd);
      wb(1'b1, CTRL_OFS, i ? 32'hF : 32'hB, rd);
      `CHK("strobe", 1'b1, tapeOut.writeStrobe)
      `CHK("seed", MINUS_ZERO, tapeOut.word)
      `CHK("seedfwd", 1'(i == 0), tapeOut.sumAtForward)
      `CHK("rev", 1'(i), tapeOut.reverse)
    end
    // The idle slot writes nothing, so the seed stays the last word out.
    waitSig(0);
    @(posedge mclk);
    `CHK("skip", MINUS_ZERO, lastStrobe)
    wb(1'b1, DATA_OFS, 32'h12345, rd);
    waitSig(0);
    @(posedge mclk);
    `CHK("wword", 18'h12345, lastStrobe)
    // At the last word a mode change must wait for the checksum.
    wb(1'b1, DATA_OFS, 32'h0ABCD, rd);
    waitSig(0);
    wb(1'b1, CTRL_OFS, 32'h9, rd);
    wb(1'b0, CTRL_OFS, 32'h0, rd);
    `CHK("defer", 32'hF, rd)
    waitSig(1);
    wb(1'b1, DATA_OFS, 32'h2AAAA, rd);
    waitSig(0);
    @(posedge mclk);
    `CHK("wsum", 18'h2AAAA, lastStrobe)
    wb(1'b0, CTRL_OFS, 32'h0, rd);
    `CHK("applied", 32'h9, rd)
    wb(1'b1, CTRL_OFS, 32'h0, rd);
    finish_test();
  end
endmodule // test_tape_word_transfer_flags
